// ### modulator_control_status_regs.v
// upper control register bank of a quadrature modulator, host side
// assumes host port pins synchronous to clock; write taken on the
// falling edge of write_n while chip_select_n is low
//
// Notes on behaviour
// - status word: full, empty, over, under, locks, done
// - enable bits match status bits, reset zero
// - carrier phase step word, reset zero
// - symbol phase step word, reset zero
// - loop filter upper clamp, reset 7FFFFFF
// - loop filter lower clamp, reset zero
// - queue clear write gives one pulse
// - buffer update write gives one copy pulse
// - key value to space four sets soft reset
// - other value to space four releases soft reset
// - nineteen bit filter seed, reset zero
// - queue write location enables sample loading
`default_nettype none
`include "modreg_defines.vh"

module modulator_control_status_regs (
    input wire clock,
    input wire rst,
    input wire [2:0] port_addr,
    input wire [7:0] config_data_bus_in,
    output reg [7:0] config_data_bus_out,
    output wire config_data_bus_oe,
    input wire chip_select_n,
    input wire write_n,
    input wire read_n,
    input wire queue_full,
    input wire queue_empty,
    input wire queue_overflow,
    input wire queue_underflow,
    input wire digital_lock,
    input wire analog_lock,
    input wire input_sample_strobe,
    output wire [31:0] carrier_phase_step,
    output wire [31:0] symbol_phase_step,
    output wire [31:0] loop_filter_max,
    output wire [31:0] loop_filter_min,
    output wire [18:0] filter_seed,
    output wire [31:0] staging_register,
    output reg queue_clear_pulse,
    output reg buffer_update_pulse,
    output reg queue_write_pulse,
    output wire queue_load,
    output reg soft_reset,
    output wire irq
);

    // ==========================================================
    // host write detection
    reg write_n_d_r;
    reg [31:0] staging_r;
    wire write_evt;
    wire xfer;
    wire [7:0] xfer_addr;

    always @(posedge clock) begin
        if (rst) begin
            write_n_d_r <= 1'b1;
        end else begin
            write_n_d_r <= write_n;
        end
    end

    assign write_evt = write_n_d_r & ~write_n & ~chip_select_n;
    assign xfer = write_evt & (port_addr == `SPACE_TRANSFER);
    assign xfer_addr = config_data_bus_in;
    assign staging_register = staging_r;

    // ==========================================================
    // staging register bytes
    always @(posedge clock) begin
        if (rst) begin
            staging_r <= 32'h00000000;
        end else if (write_evt) begin
            case (port_addr)
                `SPACE_STAGE0: staging_r[7:0] <= config_data_bus_in;
                `SPACE_STAGE1: staging_r[15:8] <= config_data_bus_in;
                `SPACE_STAGE2: staging_r[23:16] <= config_data_bus_in;
                `SPACE_STAGE3: staging_r[31:24] <= config_data_bus_in;
                default: staging_r <= staging_r;
            endcase
        end
    end

    // ==========================================================
    // control words
    wire [6:0] irq_enable;

    ctl_word #(.WIDTH(7), .RESET_VALUE(`RST_IRQ_ENABLE)) u_enable (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_IRQ_ENABLE),
        .load_value(staging_r[6:0]),
        .value_r(irq_enable)
    );

    ctl_word #(.WIDTH(32), .RESET_VALUE(`RST_CARRIER_STEP)) u_carrier (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_CARRIER_STEP),
        .load_value(staging_r),
        .value_r(carrier_phase_step)
    );

    ctl_word #(.WIDTH(32), .RESET_VALUE(`RST_SYMBOL_STEP)) u_symbol (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_SYMBOL_STEP),
        .load_value(staging_r),
        .value_r(symbol_phase_step)
    );

    ctl_word #(.WIDTH(32), .RESET_VALUE(`RST_LOOP_MAX)) u_loop_max (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_LOOP_MAX),
        .load_value(staging_r),
        .value_r(loop_filter_max)
    );

    ctl_word #(.WIDTH(32), .RESET_VALUE(`RST_LOOP_MIN)) u_loop_min (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_LOOP_MIN),
        .load_value(staging_r),
        .value_r(loop_filter_min)
    );

    ctl_word #(.WIDTH(19), .RESET_VALUE(`RST_FILTER_SEED)) u_seed (
        .clock(clock),
        .rst(rst),
        .load(xfer && xfer_addr == `ADDR_FILTER_SEED),
        .load_value(staging_r[18:0]),
        .value_r(filter_seed)
    );

    // ==========================================================
    // write strobes and soft reset
    reg queue_load_en_r;
    reg boot_r;

    always @(posedge clock) begin
        if (rst) begin
            queue_clear_pulse <= 1'b0;
            buffer_update_pulse <= 1'b0;
            queue_write_pulse <= 1'b0;
            soft_reset <= 1'b0;
            queue_load_en_r <= 1'b0;
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
            queue_clear_pulse <= xfer && xfer_addr == `ADDR_QUEUE_CLEAR;
            buffer_update_pulse <= xfer && xfer_addr == `ADDR_BUFFER_UPDATE;
            queue_write_pulse <= xfer && xfer_addr == `ADDR_QUEUE_WRITE;
            if (xfer) begin
                soft_reset <= (xfer_addr == `SOFT_RESET_KEY);
            end
            if (queue_clear_pulse) begin
                queue_load_en_r <= 1'b0;
            end else if (queue_write_pulse) begin
                queue_load_en_r <= 1'b1;
            end
        end
    end

    // samples load only after the enabling write and until a queue clear
    assign queue_load = queue_load_en_r & input_sample_strobe;

    // ==========================================================
    // interrupt status
    reg soft_reset_d_r;
    wire [6:0] irq_status;
    wire [6:0] status_set;
    wire [6:0] status_clear;
    wire reset_done_evt;

    always @(posedge clock) begin
        if (rst) begin
            soft_reset_d_r <= 1'b0;
        end else begin
            soft_reset_d_r <= soft_reset;
        end
    end

    // done after hard reset release and after soft reset falls
    assign reset_done_evt = boot_r | (soft_reset_d_r & ~soft_reset);

    assign status_set[`BIT_QUEUE_FULL] = queue_full;
    assign status_set[`BIT_QUEUE_EMPTY] = queue_empty;
    assign status_set[`BIT_QUEUE_OVERFLOW] = queue_overflow;
    assign status_set[`BIT_QUEUE_UNDERFLOW] = queue_underflow;
    assign status_set[`BIT_DIGITAL_LOCK] = digital_lock;
    assign status_set[`BIT_ANALOG_LOCK] = analog_lock;
    assign status_set[`BIT_RESET_DONE] = reset_done_evt;

    // transfer to the status address clears bits set in staging byte 0
    assign status_clear = (xfer && xfer_addr == `ADDR_IRQ_STATUS) ?
        staging_r[6:0] : 7'h00;

    sticky_flags #(.WIDTH(`IRQ_WIDTH)) u_status (
        .clock(clock),
        .rst(rst),
        .set_bits(status_set),
        .clear_bits(status_clear),
        .flags_r(irq_status)
    );

    assign irq = |(irq_status & irq_enable);

    // ==========================================================
    // readback
    reg [31:0] hold_r;
    reg [31:0] read_word;

    always @* begin
        read_word = 32'h00000000;
        case (config_data_bus_in)
            `ADDR_IRQ_STATUS: read_word = {25'h0000000, irq_status};
            `ADDR_IRQ_ENABLE: read_word = {25'h0000000, irq_enable};
            `ADDR_CARRIER_STEP: read_word = carrier_phase_step;
            `ADDR_SYMBOL_STEP: read_word = symbol_phase_step;
            `ADDR_LOOP_MAX: read_word = loop_filter_max;
            `ADDR_LOOP_MIN: read_word = loop_filter_min;
            `ADDR_FILTER_SEED: read_word = {13'h0000, filter_seed};
            default: read_word = 32'h00000000;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            hold_r <= 32'h00000000;
            config_data_bus_out <= 8'h00;
        end else begin
            if (write_evt && port_addr == `SPACE_READ_SEL) begin
                hold_r <= read_word;
            end
            case (port_addr)
                `SPACE_STAGE0: config_data_bus_out <= hold_r[7:0];
                `SPACE_STAGE1: config_data_bus_out <= hold_r[15:8];
                `SPACE_STAGE2: config_data_bus_out <= hold_r[23:16];
                `SPACE_STAGE3: config_data_bus_out <= hold_r[31:24];
                default: config_data_bus_out <= 8'h00;
            endcase
        end
    end

    assign config_data_bus_oe = ~chip_select_n & ~read_n;

endmodule // modulator_control_status_regs

`default_nettype wire

// ### modreg_defines.vh
// constants for the modulator control and status register bank
// assumes inclusion by bare name from the design files of this block
`ifndef MODREG_DEFINES_VH
`define MODREG_DEFINES_VH

// ==========================================================
// host port address spaces
`define SPACE_STAGE0 3'h0
`define SPACE_STAGE1 3'h1
`define SPACE_STAGE2 3'h2
`define SPACE_STAGE3 3'h3
`define SPACE_TRANSFER 3'h4
`define SPACE_READ_SEL 3'h5

// ==========================================================
// control word addresses
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_ENABLE 8'h09
`define ADDR_CARRIER_STEP 8'h0A
`define ADDR_SYMBOL_STEP 8'h0B
`define ADDR_LOOP_MAX 8'h0C
`define ADDR_LOOP_MIN 8'h0D
`define ADDR_QUEUE_CLEAR 8'h0E
`define ADDR_BUFFER_UPDATE 8'h0F
`define ADDR_SOFT_RESET 8'h10
`define ADDR_FILTER_SEED 8'h11
`define ADDR_QUEUE_WRITE 8'h12

// ==========================================================
// soft reset key value
`define SOFT_RESET_KEY 8'h10

// ==========================================================
// status and enable bit positions, bit 7 unused
`define IRQ_WIDTH 7
`define BIT_QUEUE_FULL 6
`define BIT_QUEUE_EMPTY 5
`define BIT_QUEUE_OVERFLOW 4
`define BIT_QUEUE_UNDERFLOW 3
`define BIT_DIGITAL_LOCK 2
`define BIT_ANALOG_LOCK 1
`define BIT_RESET_DONE 0

// ==========================================================
// widths and reset values
`define WORD_WIDTH 32
`define SEED_WIDTH 19
`define RST_IRQ_ENABLE 7'h00
`define RST_CARRIER_STEP 32'h00000000
`define RST_SYMBOL_STEP 32'h00000000
`define RST_LOOP_MAX 32'h07FFFFFF
`define RST_LOOP_MIN 32'h00000000
`define RST_FILTER_SEED 19'h00000

`endif

// ### ctl_word.v
// loadable control word with a fixed reset value
// assumes a synchronous active-high reset on the common clock
`default_nettype none

module ctl_word #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    output reg [WIDTH-1:0] value_r
);

    always @(posedge clock) begin
        if (rst) begin
            value_r <= RESET_VALUE;
        end else if (load) begin
            value_r <= load_value;
        end
    end

endmodule // ctl_word

`default_nettype wire

// ### sticky_flags.v
// sticky event flags, cleared bitwise, a set in the clear cycle wins
// assumes a synchronous active-high reset on the common clock
`default_nettype none

module sticky_flags #(
    parameter WIDTH = 7
) (
    input wire clock,
    input wire rst,
    input wire [WIDTH-1:0] set_bits,
    input wire [WIDTH-1:0] clear_bits,
    output reg [WIDTH-1:0] flags_r
);

    always @(posedge clock) begin
        if (rst) begin
            flags_r <= {WIDTH{1'b0}};
        end else begin
            flags_r <= (flags_r & ~clear_bits) | set_bits;
        end
    end

endmodule // sticky_flags

`default_nettype wire

// ### modreg_checker_properties.sv
// checker for the modulator control register bank
// assumes binding to the bank's top module
`default_nettype none
module modreg_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] port_addr,
    input wire logic [7:0] config_data_bus_in,
    input wire logic chip_select_n,
    input wire logic write_n,
    input wire logic input_sample_strobe,
    input wire logic [31:0] carrier_phase_step,
    input wire logic [31:0] loop_filter_max,
    input wire logic queue_clear_pulse,
    input wire logic buffer_update_pulse,
    input wire logic queue_write_pulse,
    input wire logic queue_load,
    input wire logic soft_reset,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // properties
    logic write_n_prev_r;
    // mirrors the bank's write edge detector, idle high out of reset
    always_ff @(posedge clock) write_n_prev_r <= rst ? 1'b1 : write_n;
    wire wr_evt = !chip_select_n && !write_n && write_n_prev_r;
    wire xfer = wr_evt && port_addr == 3'h4;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence xfer_s(a);
        xfer && config_data_bus_in == a;
    endsequence
    sequence pulse_s(p);
        p ##1 !p;
    endsequence
    soft_set_a: assert property (xfer_s(8'h10) |=> soft_reset)
        else $error("soft reset not set");
    soft_release_a: assert property (xfer && config_data_bus_in != 8'h10 |=> !soft_reset)
        else $error("soft reset not released");
    soft_hold_a: assert property (!xfer |=> $stable(soft_reset))
        else $error("soft reset moved without a write");
    queue_clear_a: assert property (xfer_s(8'h0E) |=> pulse_s(queue_clear_pulse))
        else $error("queue clear pulse wrong");
    clear_cause_a: assert property ($rose(queue_clear_pulse) |-> $past(xfer))
        else $error("queue clear pulse without write");
    buffer_pulse_a: assert property (xfer_s(8'h0F) |=> pulse_s(buffer_update_pulse))
        else $error("buffer update pulse wrong");
    queue_arm_a: assert property (xfer_s(8'h12) |=> queue_write_pulse)
        else $error("queue write pulse missing");
    queue_load_a: assert property (queue_load |-> input_sample_strobe)
        else $error("queue load without strobe");
    carrier_hold_a: assert property (!$past(rst) && !$past(xfer) |-> $stable(carrier_phase_step))
        else $error("carrier step changed without write");
    reset_vals_a: assert property ($fell(rst) |-> loop_filter_max == 32'h07FFFFFF && !irq)
        else $error("reset values wrong");
endmodule // modreg_properties
bind modulator_control_status_regs modreg_properties u_modreg_properties (
    .clock, .rst, .port_addr, .config_data_bus_in, .chip_select_n, .write_n,
    .input_sample_strobe, .carrier_phase_step, .loop_filter_max, .queue_clear_pulse,
    .buffer_update_pulse, .queue_write_pulse, .queue_load, .soft_reset, .irq);
`default_nettype wire

// ### modreg_host.sv
// host processor model on the bank's control port
// assumes the bank samples the port on the rising clock edge
`default_nettype none
module modreg_host (
    input wire logic clock,
    input wire logic [7:0] config_data_bus_out,
    input wire logic config_data_bus_oe,
    output logic [2:0] port_addr,
    output logic [7:0] config_data_bus_in,
    output logic chip_select_n,
    output logic write_n,
    output logic read_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // port cycles
    initial begin
        port_addr = 3'h7;
        config_data_bus_in = 8'h00;
        chip_select_n = 1'b1;
        write_n = 1'b1;
        read_n = 1'b1;
    end
    // write_n returns high so the next write is a fresh edge
    task automatic wr(input logic [2:0] sp, input logic [7:0] d);
        @(posedge clock);
        port_addr <= sp;
        config_data_bus_in <= d;
        chip_select_n <= 1'b0;
        write_n <= 1'b0;
        @(posedge clock);
        write_n <= 1'b1;
        chip_select_n <= 1'b1;
        config_data_bus_in <= ~d;
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] w);
        for (int b = 0; b < 4; b++) wr(3'(b), w[8*b+:8]);
        wr(3'h4, a);
    endtask
    task automatic get(input logic [7:0] a, output logic [31:0] w);
        wr(3'h5, a);
        for (int b = 0; b < 4; b++) begin
            @(posedge clock);
            port_addr <= 3'(b);
            chip_select_n <= 1'b0;
            read_n <= 1'b0;
            @(posedge clock);
            #1 w[8*b+:8] = config_data_bus_oe ? config_data_bus_out : 8'hXX;
        end
        @(posedge clock);
        chip_select_n <= 1'b1;
        read_n <= 1'b1;
    endtask
endmodule // modreg_host
`default_nettype wire

// ### tb.sv
// self-checking bench for the modulator control register bank
// assumes the host model and the bound checker are compiled first
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // bench
    logic clock, rst, input_sample_strobe;
    logic [5:0] ev;
    wire [2:0] port_addr;
    wire [7:0] config_data_bus_in, config_data_bus_out;
    wire chip_select_n, write_n, read_n, config_data_bus_oe;
    wire [31:0] carrier_phase_step, symbol_phase_step, loop_filter_max, loop_filter_min;
    wire [18:0] filter_seed;
    wire queue_clear_pulse, buffer_update_pulse, queue_write_pulse, queue_load, soft_reset, irq;
    wire [2:0] pulses = {queue_clear_pulse, buffer_update_pulse, queue_write_pulse};
    int mismatches, comparisons, cycles;
    logic [7:0] addr_t [5] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h11};
    logic [31:0] rst_t [5] = '{32'h0, 32'h0, 32'h07FFFFFF, 32'h0, 32'h0};
    logic [31:0] pat_t [5] = '{32'h12345678, 32'hFEDCBA98, 32'h80000001, 32'hFFFFFFFF,
        32'hFFFFFFFF};
    modulator_control_status_regs u_modulator_control_status_regs (
        .clock, .rst, .port_addr, .config_data_bus_in, .config_data_bus_out,
        .config_data_bus_oe, .chip_select_n, .write_n, .read_n,
        .queue_full(ev[5]), .queue_empty(ev[4]), .queue_overflow(ev[3]),
        .queue_underflow(ev[2]), .digital_lock(ev[1]), .analog_lock(ev[0]),
        .input_sample_strobe, .carrier_phase_step, .symbol_phase_step, .loop_filter_max,
        .loop_filter_min, .filter_seed, .staging_register(), .queue_clear_pulse,
        .buffer_update_pulse, .queue_write_pulse, .queue_load, .soft_reset, .irq);
    modreg_host host (.clock, .config_data_bus_out, .config_data_bus_oe, .port_addr,
        .config_data_bus_in, .chip_select_n, .write_n, .read_n);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ev_pulse(input int k);
        @(posedge clock);
        ev <= 6'(1 << k);
        @(posedge clock);
        ev <= 6'h00;
        #1;
    endtask
    task automatic t_words();
        logic [31:0] w;
        for (int i = 0; i < 5; i++) begin
            host.get(addr_t[i], w);
            chk("reset", rst_t[i], w);
            host.put(addr_t[i], pat_t[i]);
            host.get(addr_t[i], w);
            chk("word", pat_t[i] & (i == 4 ? 32'h7FFFF : 32'hFFFFFFFF), w);
        end
        chk("carrier", 32'h12345678, carrier_phase_step);
        chk("symbol", 32'hFEDCBA98, symbol_phase_step);
        chk("loop max", 32'h80000001, loop_filter_max);
        chk("loop min", 32'hFFFFFFFF, loop_filter_min);
        chk("seed", 32'h7FFFF, 32'(filter_seed));
    endtask
    task automatic t_status();
        logic [31:0] w;
        logic [7:0] e;
        e = 8'h01;
        host.get(8'h09, w);
        chk("enable", 32'h0, w);
        for (int k = 0; k < 6; k++) begin
            ev_pulse(k);
            e[k+1] = 1'b1;
            host.get(8'h08, w);
            chk("status", {24'h0, e}, w);
        end
        host.put(8'h09, 32'h40);
        host.put(8'h08, 32'hFF);
        ev_pulse(0);
        chk("masked", 0, 32'(irq));
        ev_pulse(5);
        chk("irq", 1, 32'(irq));
        host.put(8'h08, 32'hFF);
        #1 chk("irq off", 0, 32'(irq));
    endtask
    task automatic t_strobes();
        logic [7:0] sa [3] = '{8'h0F, 8'h12, 8'h0E};
        logic [2:0] se [3] = '{3'b010, 3'b001, 3'b100};
        for (int i = 0; i < 3; i++) begin
            host.wr(3'h4, sa[i]);
            #1 chk("pulse", 32'(se[i]), 32'(pulses));
            @(posedge clock);
            #1 chk("pulse end", 0, 32'(pulses));
        end
        @(posedge clock);
        input_sample_strobe <= 1'b1;
        @(posedge clock);
        #1 chk("load off", 0, 32'(queue_load));
        host.wr(3'h4, 8'h12);
        // the load enable is set one edge after the write pulse
        @(posedge clock);
        #1 chk("load on", 1, 32'(queue_load));
        @(posedge clock);
        input_sample_strobe <= 1'b0;
    endtask
    task automatic t_soft();
        logic [31:0] w;
        host.wr(3'h4, 8'h10);
        #1 chk("soft set", 1, 32'(soft_reset));
        host.wr(3'h0, 8'h10);
        #1 chk("soft held", 1, 32'(soft_reset));
        host.wr(3'h4, 8'h3F);
        #1 chk("soft off", 0, 32'(soft_reset));
        host.get(8'h08, w);
        chk("done", 32'h01, w);
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        rst = 1'b1;
        ev = 6'h00;
        input_sample_strobe = 1'b0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_words();
        t_status();
        t_strobes();
        t_soft();
        results();
    end
endmodule // tb
`default_nettype wire
